// [pkg/pbss_consts.svh]
// Functional notes
// RL1: Short press in soft-off powers on.
// RL2: Short press while working enters sleep.
// RL3: Long press while working forces soft-off.
// RL4: Short press while sleeping wakes system.
// RL5: Long press while sleeping goes soft-off.
// RL6: S1 holds processor in stop-grant.
// RL7: S3 keeps memory context, processor unpowered.
// RL8: S4 context on disk, only wake logic.
// RL9: Leaving S5 performs full cold boot.
// RL10: Wake logic powered in all sleep states.
// RL11: Mechanical-off blocks all transitions.
// RL12: Keyboard/mouse wakes only from S1, S3.
// RL13: USB wakes only from S1, S3.
// RL14: Express wake from S1, S3, S4, S5.
// RL15: Restore last on/off after mains return.
// RL16: Synchronise, debounce, time press against four seconds.
// RL17: Long press acts while still held.
`ifndef PBSS_CONSTS_SVH
`define PBSS_CONSTS_SVH
`define PBSS_CLK_PERIOD_NS   10
`define PBSS_LONG_PRESS_MS   4000
// Cycles per millisecond are worked out first, so the product stays inside 32-bit arithmetic.
`define PBSS_LONG_PRESS_CYC  (`PBSS_LONG_PRESS_MS * (1000000 / `PBSS_CLK_PERIOD_NS))
`define PBSS_DEBOUNCE_US     10000
`define PBSS_DEBOUNCE_CYC    ((`PBSS_DEBOUNCE_US * 1000) / `PBSS_CLK_PERIOD_NS)
`define PBSS_CNT_W           32
`endif

// [pkg/pbss_pkg.sv]
package pbss_pkg;
    typedef enum logic [5:0] {
        PBSS_G3 = 6'b00_0001,
        PBSS_S0 = 6'b00_0010,
        PBSS_S1 = 6'b00_0100,
        PBSS_S3 = 6'b00_1000,
        PBSS_S4 = 6'b01_0000,
        PBSS_S5 = 6'b10_0000
    } pbss_state_e;

    typedef struct packed {
        logic kbd_mouse;
        logic usb;
        logic pcie_wake;
    } pbss_wake_s;

    typedef struct packed {
        logic cpu_power;
        logic cpu_stop_grant;
        logic mem_retain;
        logic main_power;
        logic wake_logic_power;
        logic cold_boot;
    } pbss_power_s;
endpackage : pbss_pkg

// [hw/pbss_switch_timer.sv]
`timescale 1ns/1ns
`include "pbss_consts.svh"
module pbss_switch_timer
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic switch_pressed_raw,
    input  wire logic [31:0] long_cycles,
    input  wire logic [31:0] debounce_cycles,
    output logic      short_release,
    output logic      long_hit
);
    import pbss_pkg::*;

    // ----------------------------------------
    // Synchroniser, debounce and press timer
    // ----------------------------------------
    logic        sync1;
    logic        sync2;
    logic        stable;
    logic [31:0] deb_cnt;
    logic [31:0] press_cnt;
    logic        long_done;
    logic        next_stable;
    logic [31:0] next_deb_cnt;
    logic [31:0] next_press_cnt;
    logic        next_long_done;

    always_comb
    begin
        next_stable    = stable;
        next_deb_cnt   = 32'h0000_0000;
        next_press_cnt = press_cnt;
        next_long_done = long_done;
        short_release  = 1'b0;
        long_hit       = 1'b0;
        if (sync2 != stable)
        begin
            next_deb_cnt = deb_cnt + 32'h0000_0001; // RL16
            if (deb_cnt + 32'h0000_0001 >= debounce_cycles)
            begin
                next_stable  = sync2;
                next_deb_cnt = 32'h0000_0000;
            end
        end
        if (stable)
        begin
            // Saturates so a very long hold never wraps into a fake short press.
            if (press_cnt != 32'hFFFF_FFFF)
            begin
                next_press_cnt = press_cnt + 32'h0000_0001; // RL16
            end
            if (!long_done && press_cnt + 32'h0000_0001 >= long_cycles)
            begin
                long_hit       = 1'b1; // RL17
                next_long_done = 1'b1;
            end
        end
        if (stable && !next_stable)
        begin
            short_release  = !long_done && !long_hit;
            next_press_cnt = 32'h0000_0000;
            next_long_done = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sync1     <= 1'b0;
            sync2     <= 1'b0;
            stable    <= 1'b0;
            deb_cnt   <= 32'h0000_0000;
            press_cnt <= 32'h0000_0000;
            long_done <= 1'b0;
        end
        else
        begin
            sync1     <= switch_pressed_raw;
            sync2     <= sync1;
            stable    <= next_stable;
            deb_cnt   <= next_deb_cnt;
            press_cnt <= next_press_cnt;
            long_done <= next_long_done;
        end
    end
endmodule : pbss_switch_timer

// [hw/pbss_sequencer.sv]
`timescale 1ns/1ns
`include "pbss_consts.svh"
module pbss_sequencer
#(
    parameter logic [31:0] LONG_PRESS_CYC = 32'(`PBSS_LONG_PRESS_CYC),
    parameter logic [31:0] DEBOUNCE_CYC   = 32'(`PBSS_DEBOUNCE_CYC)
)
(
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic               mains_ok,
    input  wire logic               standby_batt_ok,
    input  wire logic               switch_pressed,
    input  wire pbss_pkg::pbss_wake_s wake_req,
    input  wire logic               sw_sleep_req,
    input  wire logic [1:0]         sw_sleep_kind,
    input  wire logic               sw_off_req,
    input  wire logic               restore_last_on,
    input  wire logic [1:0]         sleep_kind_cfg,
    output pbss_pkg::pbss_state_e   state,
    output pbss_pkg::pbss_power_s   power
);
    import pbss_pkg::*;

    // ----------------------------------------
    // Press events
    // ----------------------------------------
    logic short_release;
    logic long_hit;

    pbss_switch_timer u_timer
    (
        .clk                (clk),
        .srst               (srst),
        .switch_pressed_raw (switch_pressed),
        .long_cycles        (LONG_PRESS_CYC),
        .debounce_cycles    (DEBOUNCE_CYC),
        .short_release      (short_release),
        .long_hit           (long_hit)
    );

    // ----------------------------------------
    // State machine
    // ----------------------------------------
    pbss_state_e next_state;
    pbss_state_e sleep_target;
    pbss_state_e sw_target;
    logic        last_on;
    logic        next_last_on;
    logic        cold;
    logic        next_cold;
    logic        any_wake;

    always_comb
    begin
        unique case (sleep_kind_cfg)
            2'h0:    sleep_target = PBSS_S1;
            2'h1:    sleep_target = PBSS_S3;
            default: sleep_target = PBSS_S4;
        endcase
        unique case (sw_sleep_kind)
            2'h0:    sw_target = PBSS_S1;
            2'h1:    sw_target = PBSS_S3;
            default: sw_target = PBSS_S4;
        endcase
        any_wake     = wake_req.pcie_wake; // RL14
        if (state == PBSS_S1 || state == PBSS_S3)
        begin
            any_wake = any_wake | wake_req.kbd_mouse | wake_req.usb; // RL12 RL13
        end
        next_state   = state;
        next_last_on = last_on;
        next_cold    = 1'b0;
        if (!mains_ok && !standby_batt_ok)
        begin
            next_state = PBSS_G3; // RL11
        end
        else
        begin
            unique case (state)
                PBSS_G3:
                begin
                    // Mains back: restore what was on before, if enabled.
                    if (mains_ok)
                    begin
                        next_state = (restore_last_on && last_on) ? PBSS_S0 : PBSS_S5; // RL15
                        next_cold  = restore_last_on && last_on;
                    end
                end
                PBSS_S0:
                begin
                    if (long_hit || sw_off_req)
                    begin
                        next_state = PBSS_S5; // RL3
                    end
                    else if (short_release)
                    begin
                        next_state = sleep_target; // RL2
                    end
                    else if (sw_sleep_req)
                    begin
                        next_state = sw_target;
                    end
                end
                PBSS_S5:
                begin
                    if (short_release || wake_req.pcie_wake)
                    begin
                        next_state = PBSS_S0; // RL1
                        next_cold  = 1'b1; // RL9
                    end
                end
                default:
                begin
                    if (long_hit)
                    begin
                        next_state = PBSS_S5; // RL5
                    end
                    else if (short_release || any_wake)
                    begin
                        next_state = PBSS_S0; // RL4
                        next_cold  = (state == PBSS_S4);
                    end
                end
            endcase
            if (mains_ok && state != PBSS_G3)
            begin
                next_last_on = (next_state == PBSS_S0);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state   <= PBSS_G3;
            last_on <= 1'b0;
            cold    <= 1'b0;
        end
        else
        begin
            state   <= next_state;
            last_on <= next_last_on;
            cold    <= next_cold;
        end
    end

    // ----------------------------------------
    // Power rails per state
    // ----------------------------------------
    // Outputs come straight from the state register and one pulse flop, except wake_logic_power, which also follows standby_batt_ok unregistered.
    always_comb
    begin
        power.cpu_power        = (state == PBSS_S0) || (state == PBSS_S1); // RL7 RL8
        power.cpu_stop_grant   = (state == PBSS_S1); // RL6
        power.mem_retain       = (state != PBSS_G3) && (state != PBSS_S4)
                                 && (state != PBSS_S5); // RL7
        power.main_power       = (state == PBSS_S0) || (state == PBSS_S1);
        power.wake_logic_power = (state != PBSS_G3) || standby_batt_ok; // RL10 RL11
        power.cold_boot        = cold; // RL9
    end

    a_long_press_off: assert property (@(posedge clk) disable iff (srst) // RL3
        (state == PBSS_S0 && long_hit && (mains_ok || standby_batt_ok)) |=> state == PBSS_S5)
        else $error("long press in working did not reach soft-off");
    a_short_to_sleep: assert property (@(posedge clk) disable iff (srst) // RL2
        (state == PBSS_S0 && short_release && !long_hit && !sw_off_req && mains_ok)
        |=> state inside {PBSS_S1, PBSS_S3, PBSS_S4})
        else $error("short press in working did not sleep");
    a_soft_off_on: assert property (@(posedge clk) disable iff (srst) // RL1
        (state == PBSS_S5 && short_release && (mains_ok || standby_batt_ok))
        |=> state == PBSS_S0 && power.cold_boot)
        else $error("short press in soft-off did not cold boot");
    a_sleep_wake: assert property (@(posedge clk) disable iff (srst) // RL4
        (state inside {PBSS_S1, PBSS_S3} && short_release && !long_hit && mains_ok)
        |=> state == PBSS_S0)
        else $error("short press in sleep did not wake");
    a_sleep_long_off: assert property (@(posedge clk) disable iff (srst) // RL5
        (state inside {PBSS_S1, PBSS_S3, PBSS_S4} && long_hit && mains_ok) |=> state == PBSS_S5)
        else $error("long press in sleep did not reach soft-off");
    a_stop_grant: assert property (@(posedge clk) disable iff (srst) // RL6
        power.cpu_stop_grant == (state == PBSS_S1) && !(state == PBSS_S3 && power.cpu_power))
        else $error("stop-grant or processor power wrong");
    a_usb_deep_hold: assert property (@(posedge clk) disable iff (srst) // RL13
        (state == PBSS_S4 && !short_release && !long_hit && !wake_req.pcie_wake
         && (mains_ok || standby_batt_ok)) |=> state == PBSS_S4)
        else $error("deep sleep left without valid wake");
    a_g3_frozen: assert property (@(posedge clk) disable iff (srst) // RL11
        (!mains_ok && !standby_batt_ok) |=> state == PBSS_G3)
        else $error("transition while mechanically off");
    a_wake_powered: assert property (@(posedge clk) disable iff (srst) // RL10
        state inside {PBSS_S1, PBSS_S3, PBSS_S4, PBSS_S5} |-> power.wake_logic_power)
        else $error("wake logic unpowered in sleep");
endmodule : pbss_sequencer

// [sim/pbss_panel_model.sv]
`timescale 1ns/1ns
module pbss_panel_model
(
    input  wire logic            clk,
    output logic                 switch_pressed,
    output pbss_pkg::pbss_wake_s wake_req
);
    import pbss_pkg::*;
    // ------------------------------------------------------------
    // Front panel switch and wake sources
    // ------------------------------------------------------------
    initial
    begin
        switch_pressed = 1'b0;
        wake_req       = '0;
    end
    // Every press starts with a bounce, as real contacts do.
    task hold();
        @(posedge clk);
        #1 switch_pressed = 1'b1;
        @(posedge clk);
        #1 switch_pressed = 1'b0;
        @(posedge clk);
        #1 switch_pressed = 1'b1;
    endtask : hold
    task release_sw();
        @(posedge clk);
        #1 switch_pressed = 1'b0;
    endtask : release_sw
    task wake(input pbss_wake_s src);
        @(posedge clk);
        #1 wake_req = src;
        repeat (6) @(posedge clk);
        #1 wake_req = '0;
    endtask : wake
endmodule : pbss_panel_model

// [sim/pbss_tb.sv]
`timescale 1ns/1ns
module testbench;
    import pbss_pkg::*;
    // ------------------------------------------------------------
    // Short counts keep the run brief; expectations follow them.
    // ------------------------------------------------------------
    localparam logic [31:0] LONG_CYC = 32'h0000_0028;
    localparam logic [31:0] DEB_CYC  = 32'h0000_0003;
    logic        clk;
    logic        srst;
    logic        mains_ok;
    logic        batt_ok;
    logic        switch_pressed;
    logic        restore;
    logic [1:0]  kind_cfg;
    logic        boot_seen;
    logic        sw_sleep;
    logic [1:0]  sw_kind;
    logic        sw_off;
    pbss_wake_s  wake_req;
    pbss_state_e state;
    pbss_power_s power;
    int          errors;
    int          tests_run;
    pbss_sequencer #(.LONG_PRESS_CYC(LONG_CYC), .DEBOUNCE_CYC(DEB_CYC)) u_pbss_sequencer
    (
        .clk(clk), .srst(srst), .mains_ok(mains_ok), .standby_batt_ok(batt_ok),
        .switch_pressed(switch_pressed), .wake_req(wake_req), .sw_sleep_req(sw_sleep),
        .sw_sleep_kind(sw_kind), .sw_off_req(sw_off), .restore_last_on(restore),
        .sleep_kind_cfg(kind_cfg), .state(state), .power(power)
    );
    pbss_panel_model u_pbss_panel_model
    (
        .clk(clk), .switch_pressed(switch_pressed), .wake_req(wake_req)
    );
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // The boot pulse lasts one cycle, so it is latched rather than polled.
    always @(power.cold_boot)
        if (power.cold_boot === 1'b1) boot_seen = 1'b1;
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task wrap_up();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    task check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task wait_state(input pbss_state_e exp, input int bound);
        for (int i = 0; i < bound; i++)
        begin
            @(posedge clk);
            #1;
            if (state === exp) return;
        end
        errors++;
        $display("Error at %0t: seen %h expected %h", $time, state, exp);
        wrap_up();
    endtask : wait_state
    task press(input pbss_state_e exp);
        u_pbss_panel_model.hold();
        repeat (15) @(posedge clk);
        u_pbss_panel_model.release_sw();
        wait_state(exp, 60);
    endtask : press
    task stay(input pbss_state_e exp);
        repeat (20) @(posedge clk);
        #1 check(state, exp);
    endtask : stay
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_power_on();
        wait_state(PBSS_S5, 20);
        check(power.wake_logic_power, 8'h01);
        boot_seen = 1'b0;
        press(PBSS_S0);
        check(boot_seen, 8'h01);
        $display("test power_on done");
    endtask : t_power_on
    task t_sleep_kinds();
        pbss_state_e tgt [3];
        logic [7:0]  rails;
        tgt = '{PBSS_S1, PBSS_S3, PBSS_S4};
        for (int i = 0; i < 3; i++)
        begin
            kind_cfg = 2'(i);
            press(tgt[i]);
            rails = {3'h0, power.cpu_stop_grant, power.cpu_power, power.main_power,
                     power.mem_retain, power.wake_logic_power};
            if (i == 0) check(rails, 8'h1F);
            if (i == 1) check(rails, 8'h03);
            if (i == 2) check(rails, 8'h01);
            boot_seen = 1'b0;
            press(PBSS_S0);
            check(boot_seen, (i == 2) ? 8'h01 : 8'h00);
        end
        $display("test sleep_kinds done");
    endtask : t_sleep_kinds
    task t_long_press();
        u_pbss_panel_model.hold();
        repeat (30) @(posedge clk);
        #1 check(state, PBSS_S0);
        wait_state(PBSS_S5, 50);
        u_pbss_panel_model.release_sw();
        stay(PBSS_S5);
        press(PBSS_S0);
        kind_cfg = 2'h1;
        press(PBSS_S3);
        u_pbss_panel_model.hold();
        wait_state(PBSS_S5, 80);
        u_pbss_panel_model.release_sw();
        stay(PBSS_S5);
        $display("test long_press done");
    endtask : t_long_press
    task t_wake_sources();
        boot_seen = 1'b0;
        u_pbss_panel_model.wake(pbss_wake_s'(3'h1));
        wait_state(PBSS_S0, 20);
        check(boot_seen, 8'h01);
        kind_cfg = 2'h2;
        press(PBSS_S4);
        u_pbss_panel_model.wake(pbss_wake_s'(3'h4));
        stay(PBSS_S4);
        u_pbss_panel_model.wake(pbss_wake_s'(3'h2));
        stay(PBSS_S4);
        u_pbss_panel_model.wake(pbss_wake_s'(3'h1));
        wait_state(PBSS_S0, 20);
        kind_cfg = 2'h1;
        press(PBSS_S3);
        u_pbss_panel_model.wake(pbss_wake_s'(3'h2));
        wait_state(PBSS_S0, 20);
        press(PBSS_S3);
        u_pbss_panel_model.wake(pbss_wake_s'(3'h4));
        wait_state(PBSS_S0, 20);
        $display("test wake_sources done");
    endtask : t_wake_sources
    task t_os_requests();
        sw_kind = 2'h1;
        sw_sleep = 1'b1;
        wait_state(PBSS_S3, 20);
        sw_sleep = 1'b0;
        check(power.mem_retain, 8'h01);
        press(PBSS_S0);
        sw_off = 1'b1;
        wait_state(PBSS_S5, 20);
        sw_off = 1'b0;
        check(power.mem_retain, 8'h00);
        boot_seen = 1'b0;
        press(PBSS_S0);
        check(boot_seen, 8'h01);
        $display("test os_requests done");
    endtask : t_os_requests
    task t_mains_loss();
        mains_ok = 1'b0;
        stay(PBSS_S0);
        batt_ok = 1'b0;
        wait_state(PBSS_G3, 20);
        check(power.wake_logic_power, 8'h00);
        press(PBSS_G3);
        stay(PBSS_G3);
        restore = 1'b1;
        boot_seen = 1'b0;
        mains_ok = 1'b1;
        wait_state(PBSS_S0, 20);
        check(boot_seen, 8'h01);
        $display("test mains_loss done");
    endtask : t_mains_loss
    initial
    begin
        errors = 0;
        tests_run = 0;
        boot_seen = 1'b0;
        srst = 1'b1;
        mains_ok = 1'b1;
        batt_ok = 1'b1;
        restore = 1'b0;
        kind_cfg = 2'h0;
        sw_sleep = 1'b0;
        sw_kind = 2'h0;
        sw_off = 1'b0;
        repeat (8) @(posedge clk);
        #1 srst = 1'b0;
        t_power_on();
        t_sleep_kinds();
        t_long_press();
        t_wake_sources();
        t_os_requests();
        t_mains_loss();
        wrap_up();
    end
endmodule : testbench
